/* File: fcc_crc_byte.sv */
// One byte step of the frame checksum, lsb of the byte first
module fcc_crc_byte
   import fcc_pkg::*;
(
   input  wire logic [15:0] crc_i,
   input  wire logic [7:0]  data_i,
   output logic      [15:0] crc_o
);

   logic [15:0] stage [0:8];

   assign stage[0] = crc_i;

   // -------------------------------------------------------------------
   // Bit-serial division unrolled per bit
   // -------------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < FCC_BYTE_W; b = b + 1) begin : g_bit
         logic fb;
         assign fb = stage[b][0] ^ data_i[b]; // [RULE2] [RULE7] [RULE9]
         assign stage[b+1] = fb ? ((stage[b] >> 1) ^ FCC_POLY_REFL)
                                : (stage[b] >> 1);
      end
   endgenerate

   assign crc_o = stage[FCC_BYTE_W];

endmodule

/* File: fcc_frame_check.sv */
// Frame checksum generator and checker for the transmit and receive paths
// What this block does
// RULE1 - A 16-bit cyclic check is made on send and checked on receive.
// RULE2 - The divisor is x^16 + x^12 + x^5 + 1 for both directions.
// RULE3 - Only the bytes after the length byte are covered, never the length.
// RULE4 - The 16-bit check value fills the last two bytes of each frame; on send the block appends it only with auto-insert on and length at least 3.
// RULE5 - Every received frame is checked and the outcome kept in a valid bit.
// RULE6 - On send the check bytes are appended when auto-insert is on and the length is at least 3.
// RULE7 - Check is message, first bit highest, times x^16 mod the divisor.
// RULE8 - The check field runs from the x^15 term down to the constant term.
// RULE9 - Bit b0 is sent first of the message and bit r0 first of the check.
// RULE10 - Auto-insert with length 3 to 127 covers the first N-2 bytes.
// RULE11 - The valid bit changes only at the frame end event of a reception.
// RULE12 - The remainder starts at zero and is sent without inversion.
module fcc_frame_check
   import fcc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        tx_auto_check_en_i,
   input  wire logic        tx_start_i,
   input  wire logic [6:0]  tx_len_i,
   input  wire logic        tx_src_valid_i,
   input  wire logic [7:0]  tx_src_data_i,
   output logic             tx_src_ready_o,
   output logic             tx_out_valid_o,
   output fcc_byte_t        tx_out_o,
   input  wire logic        tx_out_ready_i,
   output logic             tx_busy_o,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output logic             frame_end_event_o,
   output logic             rx_check_valid_o
);

   // -------------------------------------------------------------------
   // Transmit state
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      FCC_TX_IDLE,
      FCC_TX_HDR,
      FCC_TX_BODY,
      FCC_TX_FCS_LO,
      FCC_TX_FCS_HI
   } fcc_tx_state_t;

   fcc_tx_state_t tx_state;
   fcc_tx_state_t next_tx_state;
   logic [6:0]    tx_len;
   logic [6:0]    next_tx_len;
   logic [6:0]    tx_body;
   logic [6:0]    next_tx_body;
   logic [6:0]    tx_cnt;
   logic [6:0]    next_tx_cnt;
   logic          tx_append;
   logic          next_tx_append;
   logic [15:0]   tx_crc;
   logic [15:0]   next_tx_crc;
   logic [15:0]   tx_crc_step;
   logic          out_valid;
   logic          next_out_valid;
   fcc_byte_t     out_byte;
   fcc_byte_t     next_out_byte;
   logic          can_load;
   logic          src_take;

   fcc_crc_byte u_tx_crc (
      .crc_i  (tx_crc),
      .data_i (tx_src_data_i),
      .crc_o  (tx_crc_step)
   );

   assign can_load       = !out_valid || tx_out_ready_i;
   assign tx_src_ready_o = (tx_state == FCC_TX_BODY) && can_load;
   assign src_take       = tx_src_ready_o && tx_src_valid_i;
   assign tx_out_valid_o = out_valid;
   assign tx_out_o       = out_byte;
   assign tx_busy_o      = (tx_state != FCC_TX_IDLE) || out_valid;

   always_comb begin
      next_tx_state  = tx_state;
      next_tx_len    = tx_len;
      next_tx_body   = tx_body;
      next_tx_cnt    = tx_cnt;
      next_tx_append = tx_append;
      next_tx_crc    = tx_crc;
      next_out_valid = out_valid && !tx_out_ready_i;
      next_out_byte  = out_byte;
      case (tx_state)
         FCC_TX_IDLE: begin
            if (tx_start_i && !out_valid) begin
               next_tx_len    = tx_len_i;
               next_tx_cnt    = FCC_ZERO_LEN;
               next_tx_crc    = FCC_CRC_INIT; // [RULE12]
               // Short frames cannot hold a check field
               next_tx_append = tx_auto_check_en_i && // [RULE6] [RULE10]
                                (tx_len_i >= FCC_LEN_MIN_TX);
               next_tx_body   = next_tx_append ? tx_len_i - FCC_FCS_BYTES
                                               : tx_len_i; // [RULE10]
               next_tx_state  = FCC_TX_HDR;
            end
         end
         FCC_TX_HDR: begin
            if (can_load) begin
               // Length byte goes out but stays outside the checksum
               next_out_valid     = 1'b1;
               next_out_byte.data = {1'b0, tx_len}; // [RULE3]
               next_out_byte.last = (tx_body == FCC_ZERO_LEN) && !tx_append;
               if (tx_body != FCC_ZERO_LEN) begin
                  next_tx_state = FCC_TX_BODY;
               end else if (tx_append) begin
                  next_tx_state = FCC_TX_FCS_LO;
               end else begin
                  next_tx_state = FCC_TX_IDLE;
               end
            end
         end
         FCC_TX_BODY: begin
            if (src_take) begin
               next_out_valid     = 1'b1;
               next_out_byte.data = tx_src_data_i;
               next_tx_crc        = tx_crc_step; // [RULE1] [RULE3]
               next_tx_cnt        = tx_cnt + FCC_ONE;
               next_out_byte.last = (next_tx_cnt == tx_body) && !tx_append;
               if (next_tx_cnt == tx_body) begin
                  // Remaining buffer bytes are never read
                  next_tx_state = tx_append ? FCC_TX_FCS_LO
                                            : FCC_TX_IDLE; // [RULE6]
               end
            end
         end
         FCC_TX_FCS_LO: begin
            if (can_load) begin
               // r0 sits in bit 0 and is sent first
               next_out_valid     = 1'b1;
               next_out_byte.data = tx_crc[7:0]; // [RULE4] [RULE8] [RULE9]
               next_out_byte.last = 1'b0;
               next_tx_state      = FCC_TX_FCS_HI;
            end
         end
         FCC_TX_FCS_HI: begin
            if (can_load) begin
               next_out_valid     = 1'b1;
               next_out_byte.data = tx_crc[15:8]; // [RULE4] [RULE8]
               next_out_byte.last = 1'b1;
               next_tx_state      = FCC_TX_IDLE;
            end
         end
         default: begin
            next_tx_state = FCC_TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state  <= FCC_TX_IDLE;
         tx_len    <= FCC_ZERO_LEN;
         tx_body   <= FCC_ZERO_LEN;
         tx_cnt    <= FCC_ZERO_LEN;
         tx_append <= 1'b0;
         tx_crc    <= FCC_CRC_INIT;
         out_valid <= 1'b0;
         out_byte  <= FCC_BYTE_RST;
      end else begin
         tx_state  <= next_tx_state;
         tx_len    <= next_tx_len;
         tx_body   <= next_tx_body;
         tx_cnt    <= next_tx_cnt;
         tx_append <= next_tx_append;
         tx_crc    <= next_tx_crc;
         out_valid <= next_out_valid;
         out_byte  <= next_out_byte;
      end
   end

   // -------------------------------------------------------------------
   // Receive check
   // -------------------------------------------------------------------
   typedef enum logic {
      FCC_RX_LEN,
      FCC_RX_BODY
   } fcc_rx_state_t;

   fcc_rx_state_t rx_state;
   fcc_rx_state_t next_rx_state;
   logic [6:0]    rx_len;
   logic [6:0]    next_rx_len;
   logic [6:0]    rx_left;
   logic [6:0]    next_rx_left;
   logic [15:0]   rx_crc;
   logic [15:0]   next_rx_crc;
   logic [15:0]   rx_crc_step;
   logic          rx_valid_bit;
   logic          next_rx_valid_bit;
   logic          rx_end;
   logic          next_rx_end;

   fcc_crc_byte u_rx_crc (
      .crc_i  (rx_crc),
      .data_i (rx_data_i),
      .crc_o  (rx_crc_step)
   );

   assign frame_end_event_o = rx_end;
   assign rx_check_valid_o  = rx_valid_bit;

   always_comb begin
      next_rx_state     = rx_state;
      next_rx_len       = rx_len;
      next_rx_left      = rx_left;
      next_rx_crc       = rx_crc;
      next_rx_valid_bit = rx_valid_bit;
      next_rx_end       = 1'b0;
      case (rx_state)
         FCC_RX_LEN: begin
            if (rx_valid_i) begin
               next_rx_len  = rx_data_i[FCC_LEN_W-1:0];
               next_rx_left = rx_data_i[FCC_LEN_W-1:0];
               next_rx_crc  = FCC_CRC_INIT; // [RULE3] [RULE12]
               if (rx_data_i[FCC_LEN_W-1:0] == FCC_ZERO_LEN) begin
                  next_rx_end       = 1'b1; // [RULE11]
                  next_rx_valid_bit = 1'b0; // [RULE5]
               end else begin
                  next_rx_state = FCC_RX_BODY;
               end
            end
         end
         FCC_RX_BODY: begin
            if (rx_valid_i) begin
               // Check bytes run through too; good frames leave zero
               next_rx_crc  = rx_crc_step; // [RULE1] [RULE2]
               next_rx_left = rx_left - FCC_ONE;
               if (rx_left == FCC_ONE) begin
                  next_rx_end       = 1'b1; // [RULE11]
                  next_rx_valid_bit = (rx_len >= FCC_LEN_MIN_RX) &&
                                      (rx_crc_step == FCC_CRC_RESID); // [RULE5]
                  next_rx_state     = FCC_RX_LEN;
               end
            end
         end
         default: begin
            next_rx_state = FCC_RX_LEN;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state     <= FCC_RX_LEN;
         rx_len       <= FCC_ZERO_LEN;
         rx_left      <= FCC_ZERO_LEN;
         rx_crc       <= FCC_CRC_INIT;
         rx_valid_bit <= 1'b0;
         rx_end       <= 1'b0;
      end else begin
         rx_state     <= next_rx_state;
         rx_len       <= next_rx_len;
         rx_left      <= next_rx_left;
         rx_crc       <= next_rx_crc;
         rx_valid_bit <= next_rx_valid_bit; // [RULE11]
         rx_end       <= next_rx_end;
      end
   end

endmodule

/* File: fcc_frame_check_monitor.sv */
// Port-level checker for the frame checksum block
module fcc_frame_check_monitor
   import fcc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        tx_auto_check_en_i,
   input  wire logic        tx_start_i,
   input  wire logic [6:0]  tx_len_i,
   input  wire logic        tx_src_valid_i,
   input  wire logic [7:0]  tx_src_data_i,
   input  wire logic        tx_src_ready_o,
   input  wire logic        tx_out_valid_o,
   input  wire fcc_byte_t   tx_out_o,
   input  wire logic        tx_out_ready_i,
   input  wire logic        tx_busy_o,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        frame_end_event_o,
   input  wire logic        rx_check_valid_o
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // -------------------------------------------------------------------
   // Receive byte tracker
   // -------------------------------------------------------------------
   logic       rx_in;
   logic [6:0] rx_left;
   wire        last_take = rx_valid_i &&
               (rx_in ? rx_left == 7'h01 : rx_data_i[6:0] == 7'h00);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_in   <= 1'b0;
         rx_left <= 7'h00;
      end else if (rx_valid_i) begin
         rx_in   <= !last_take;
         rx_left <= rx_in ? rx_left - 7'h01 : rx_data_i[6:0];
      end
   end

   // -------------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------------
   chk_len_first: assert property (tx_start_i && !tx_busy_o |-> ##2
      tx_out_valid_o && tx_out_o.data == {1'b0, $past(tx_len_i, 2)})
      else $error("length byte not first");
   chk_busy_start: assert property (tx_start_i && !tx_busy_o |=>
      tx_busy_o) else $error("busy not raised");
   chk_out_stands: assert property (tx_out_valid_o &&
      !tx_out_ready_i |=> tx_out_valid_o && $stable(tx_out_o))
      else $error("byte dropped");
   chk_last_ends: assert property (tx_out_valid_o && tx_out_ready_i
      && tx_out_o.last |=> !tx_out_valid_o && !tx_busy_o)
      else $error("frame not closed");
   chk_src_gate: assert property (tx_src_ready_o |->
      tx_busy_o && (tx_out_ready_i || !tx_out_valid_o))
      else $error("source read while output full");
   chk_end_timing: assert property (last_take |=> frame_end_event_o)
      else $error("frame end missing");
   chk_no_stray_end: assert property (frame_end_event_o |->
      $past(last_take)) else $error("frame end unexpected");
   chk_short_bad: assert property (last_take && !rx_in |=>
      !rx_check_valid_o) else $error("empty frame marked valid");
   chk_valid_hold: assert property ($changed(rx_check_valid_o) |->
      frame_end_event_o) else $error("valid bit moved");
endmodule

bind fcc_frame_check fcc_frame_check_monitor fcc_frame_check_monitor_inst (
   .clk_i, .rst_i, .tx_auto_check_en_i, .tx_start_i, .tx_len_i,
   .tx_src_valid_i, .tx_src_data_i, .tx_src_ready_o, .tx_out_valid_o,
   .tx_out_o, .tx_out_ready_i, .tx_busy_o, .rx_valid_i, .rx_data_i,
   .frame_end_event_o, .rx_check_valid_o);

/* File: fcc_frame_check_test.sv */
// Self-checking bench for the frame checksum block
module fcc_frame_check_test
   import fcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       auto_en = 1'b1;
   logic       start = 1'b0;
   logic [6:0] len = 7'h00;
   logic       src_v = 1'b0;
   logic [7:0] src_d = 8'h00;
   logic       rx_v = 1'b0;
   logic [7:0] rx_d = 8'h00;
   logic       stall = 1'b0;
   logic       src_r, out_v, out_r, busy, fend, cvalid, got;
   fcc_byte_t  out_b, got_b;
   int         n_fail = 0;
   int         checked = 0;
   logic [8:0] seen[$];

   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) if (got) seen.push_back(got_b);

   fcc_frame_check fcc_frame_check_inst (.clk_i, .rst_i,
      .tx_auto_check_en_i(auto_en), .tx_start_i(start), .tx_len_i(len),
      .tx_src_valid_i(src_v), .tx_src_data_i(src_d), .tx_src_ready_o(src_r),
      .tx_out_valid_o(out_v), .tx_out_o(out_b), .tx_out_ready_i(out_r),
      .tx_busy_o(busy), .rx_valid_i(rx_v), .rx_data_i(rx_d),
      .frame_end_event_o(fend), .rx_check_valid_o(cvalid));
   fcc_modem_model fcc_modem_model_inst (.clk_i, .rst_i, .stall_i(stall),
      .valid_i(out_v), .byte_i(out_b), .ready_o(out_r), .got_o(got),
      .got_byte_o(got_b));

   task automatic check(input logic [8:0] act, input logic [8:0] exp);
      checked++;
      if (act !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, act, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Reference remainder, lsb of each byte first, zero start
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'h0000;
      foreach (b[i]) for (int k = 0; k < 8; k++) begin
         c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      return c;
   endfunction

   task automatic run_tx(input logic a, input logic [7:0] body[$],
                         input logic [6:0] n, input logic st);
      int          idx;
      int          k;
      logic        app;
      logic [15:0] c;
      logic [8:0]  exp[$];
      idx = 0;
      seen = {};
      app = a && n >= 7'h03;
      c = crc(body);
      exp.push_back({1'b0, 1'b0, n});
      foreach (body[i]) exp.push_back({!app && i == body.size() - 1, body[i]});
      if (app) exp.push_back({1'b0, c[7:0]});
      if (app) exp.push_back({1'b1, c[15:8]});
      @(posedge clk_i);
      stall <= st;
      auto_en <= a;
      len <= n;
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      for (k = 0; k < 200 && seen.size() < exp.size(); k++) begin
         if (src_v && src_r) idx++;
         src_v <= idx < body.size();
         src_d <= idx < body.size() ? body[idx] : 8'h00;
         @(posedge clk_i);
      end
      src_v <= 1'b0;
      if (k == 200) begin
         n_fail++;
         tally_and_finish();
      end
      check(9'(idx), 9'(body.size()));
      foreach (exp[i]) check(seen[i], exp[i]);
   endtask

   task automatic send_rx(input logic [7:0] f[$], input logic ok);
      foreach (f[i]) begin
         @(posedge clk_i);
         rx_v <= 1'b1;
         rx_d <= f[i];
      end
      @(posedge clk_i);
      rx_v <= 1'b0;
      @(negedge clk_i);
      check({8'h00, fend}, 9'h001);
      check({8'h00, cvalid}, {8'h00, ok});
      repeat (3) @(negedge clk_i);
      check({8'h00, cvalid}, {8'h00, ok});
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      run_tx(1'b1, {8'h02, 8'h00, 8'h6a}, 7'h05, 1'b1);
      check(seen[4], 9'h0e4);
      check(seen[5], 9'h179);
      run_tx(1'b0, {8'h11, 8'h22, 8'h33, 8'h44}, 7'h04, 1'b0);
      run_tx(1'b1, {8'ha5}, 7'h03, 1'b1);
      run_tx(1'b1, {8'h5a, 8'h3c}, 7'h02, 1'b0);
      send_rx({8'h05, 8'h02, 8'h00, 8'h6a, 8'he4, 8'h79}, 1'b1);
      send_rx({8'h01, 8'h00}, 1'b0);
      send_rx({8'h05, 8'h02, 8'h00, 8'h6b, 8'he4, 8'h79}, 1'b0);
      send_rx({8'h00}, 1'b0);
      send_rx({8'h03, 8'h5a, 8'h00, 8'h00}, 1'b0);
      tally_and_finish();
   end
endmodule

/* File: fcc_modem_model.sv */
// Modulator side sink for transmitted bytes, with optional stalling
module fcc_modem_model
   import fcc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        stall_i,
   input  wire logic        valid_i,
   input  wire fcc_byte_t   byte_i,
   output logic             ready_o,
   output logic             got_o,
   output fcc_byte_t        got_byte_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Stalling toggles ready every cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_o    <= 1'b0;
         got_o      <= 1'b0;
         got_byte_o <= FCC_BYTE_RST;
      end else begin
         got_o      <= valid_i && ready_o;
         got_byte_o <= byte_i;
         ready_o    <= stall_i ? !ready_o : 1'b1;
      end
   end
endmodule

/* File: fcc_pkg.sv */
// Shared constants and types for the frame checksum block
package fcc_pkg;

   // -------------------------------------------------------------------
   // Checksum constants
   // -------------------------------------------------------------------
   // Divisor of x^16 + x^12 + x^5 + 1, bit-reversed for lsb-first order
   localparam logic [15:0] FCC_POLY_REFL  = 16'h8408;
   localparam logic [15:0] FCC_CRC_INIT   = 16'h0000;
   localparam logic [15:0] FCC_CRC_RESID  = 16'h0000;
   localparam int          FCC_CRC_W      = 16;
   localparam int          FCC_BYTE_W     = 8;

   // -------------------------------------------------------------------
   // Frame length limits
   // -------------------------------------------------------------------
   localparam int          FCC_LEN_W      = 7;
   localparam logic [6:0]  FCC_LEN_MIN_TX = 7'h03;
   localparam logic [6:0]  FCC_LEN_MIN_RX = 7'h02;
   localparam logic [6:0]  FCC_FCS_BYTES  = 7'h02;
   localparam logic [6:0]  FCC_ONE        = 7'h01;
   localparam logic [6:0]  FCC_ZERO_LEN   = 7'h00;

   // -------------------------------------------------------------------
   // Carrier of one outgoing byte
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } fcc_byte_t;

   localparam fcc_byte_t FCC_BYTE_RST = '{last: 1'b0, data: 8'h00};

endpackage
